// ---- hw/fault_resp_pkg.sv ----
// shared constants for the converter fault-response controller
package fault_resp_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_RESP    = 8'h00;
	localparam logic [7:0] OFS_MASK    = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_STATE   = 8'h0c;
	localparam logic [7:0] OFS_SSTIME  = 8'h10;
	// response field positions inside the response register, two bits each except the one-bit overvoltage select
	localparam int POS_LSOC = 0;
	localparam int POS_HSOC = 2;
	localparam int POS_OV   = 4;
	localparam int POS_UV   = 6;
	localparam int POS_TON  = 8;
	localparam int POS_OT   = 10;
	localparam int POS_OVSEL = 12;
	localparam int RESP_W = 13;
	// fault response encodings
	localparam logic [1:0] RESP_LATCH   = 2'h0;
	localparam logic [1:0] RESP_RESTART = 2'h1;
	localparam logic [1:0] RESP_IGNORE  = 2'h2;
	// status bit positions
	localparam int ST_LSOC = 0;
	localparam int ST_HSOC = 1;
	localparam int ST_OV   = 2;
	localparam int ST_UV   = 3;
	localparam int ST_TON  = 4;
	localparam int ST_OT   = 5;
	localparam int ST_BGOT = 6;
	localparam int ST_UVLO = 7;
	localparam int ST_WARN = 8;
	localparam int NSTAT   = 9;
	// reset values
	localparam logic [RESP_W-1:0] RESP_RST = 13'h0555;
	localparam logic [NSTAT-1:0]  MASK_RST = 9'h000;
	// timing
	localparam int OC_DELAY_COUNTS = 3;
	localparam int RESTART_MULT    = 7;
	localparam int SS_RST_CYCLES   = 1000;
	typedef enum logic [2:0] {
		ST_SOFT  = 3'b000,
		ST_RUN   = 3'b001,
		ST_OCDLY = 3'b011,
		ST_OFF   = 3'b010,
		ST_WAIT  = 3'b110,
		ST_LATCH = 3'b111
	} ctrl_state_t;
endpackage : fault_resp_pkg

// ---- hw/fault_resp_ctrl.sv ----
// fault-response controller for a step-down converter, with apb registers
// Functional notes
// - latch-off low-side overcurrent waits three modulation counts, then forces both switches off and power-good low.
// - restart low-side overcurrent switches off after three counts and restarts after seven soft-start times.
// - an ignored low-side overcurrent fault leaves switches under modulator control and power-good high.
// - restart high-side overcurrent switches off after three counts and restarts after seven soft-start times.
// - an ignored high-side overcurrent applies a peak current limit on every switching cycle.
// - overvoltage turns the high side off and the low side on, latched or until feedback is below 0.2 V per the select bit.
// - restart overvoltage restarts seven soft-start times after the discharge, with power-good low.
// - warnings keep modulator control and pull power-good low unless the matching fault is ignored.
// - undervoltage is not acted on during soft-start, startup timeout is declared at its end, and on restart both retry after seven soft-start times.
// - overtemperature keeps both switches off until the temperature is 20 degrees below the trip point.
// - bandgap overtemperature cannot be ignored and always turns both switches off until bandgapOt clears, without waiting for tempCooled.
// - a declared fault sets its status flag and asserts the bus alert unless masked.
// - undervoltage during startup is deferred until the startup timeout expires.
// - power-good is pulled low whenever any fault whose response is not ignore is present.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fault_resp_ctrl
	import fault_resp_pkg::*;
#(
	parameter int SS_DEFAULT = SS_RST_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// modulator and comparators, asynchronous pins
	input  wire logic        pwmTick,
	input  wire logic        pwmHigh,
	input  wire logic        lowSideOc,
	input  wire logic        highSideOc,
	input  wire logic        outOv,
	input  wire logic        outUv,
	input  wire logic        fbBelowDischarge,
	input  wire logic        overTemp,
	input  wire logic        tempCooled,
	input  wire logic        bandgapOt,
	input  wire logic        inputUvlo,
	input  wire logic        ocWarn,
	input  wire logic        ovWarn,
	input  wire logic        otWarn,
	input  wire logic        uvWarn,
	// power stage and status pins
	output logic             highSideOn,
	output logic             lowSideOn,
	output logic             peakLimitEn,
	output logic             softStartActive,
	output logic             power_good_out,
	output logic             alertOut_n
);
	// soft-start time register is 16 bits and a zero time would stall restarts
	if (SS_DEFAULT < 1 || SS_DEFAULT > 32'hffff) begin : g_bad_ss
		$error("soft start default out of range");
	end

	localparam int NIN = 15;
	typedef struct packed {
		logic [NIN-1:0]    sync1;
		logic [NIN-1:0]    sync2;
		logic              tickPrev;
		logic [RESP_W-1:0] resp;
		logic [NSTAT-1:0]  mask;
		logic [NSTAT-1:0]  status;
		logic [15:0]       ssTime;
		ctrl_state_t       state;
		logic [1:0]        ocCnt;
		logic [18:0]       timer;
		logic              ssDone;
		logic              discharge;
		logic              waitCool;
		logic [31:0]       rdata;
		logic              hs;
		logic              ls;
		logic              pg;
		logic              peak;
	} state_t;
	state_t cur_reg;
	state_t cur_next;

	function automatic logic [1:0] respOf(input logic [RESP_W-1:0] r, input int pos);
		respOf = r[pos +: 2];
	endfunction : respOf

	// synchronised inputs
	logic tick, pwm, lsOc, hsOc, ov, uv, fbLow, ot, cool, bgOt, uvlo, wOc, wOv, wOt, wUv;
	assign {tick, pwm, lsOc, hsOc, ov, uv, fbLow, ot, cool, bgOt, uvlo, wOc, wOv, wOt, wUv}
		= cur_reg.sync2;

	logic tickPulse, apbWr, apbRd, ignLs, ignHs, ignOv, restartDue;
	logic [NSTAT-1:0] events;
	logic [18:0] restartCycles;
	assign tickPulse = tick & ~cur_reg.tickPrev;
	assign apbWr = psel & penable & pwrite;
	assign apbRd = psel & ~penable & ~pwrite;
	assign ignLs = respOf(cur_reg.resp, POS_LSOC) == RESP_IGNORE;
	assign ignHs = respOf(cur_reg.resp, POS_HSOC) == RESP_IGNORE;
	assign ignOv = respOf(cur_reg.resp, POS_OV) == RESP_IGNORE;
	assign restartCycles = 19'(RESTART_MULT) * 19'(cur_reg.ssTime);
	assign restartDue = cur_reg.timer >= restartCycles;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		cur_next = cur_reg;
		cur_next.sync1 = {pwmTick, pwmHigh, lowSideOc, highSideOc, outOv, outUv,
			fbBelowDischarge, overTemp, tempCooled, bandgapOt, inputUvlo, ocWarn,
			ovWarn, otWarn, uvWarn};
		cur_next.sync2 = cur_reg.sync1;
		cur_next.tickPrev = tick;
		events = '0;
		events[ST_LSOC] = lsOc;
		events[ST_HSOC] = hsOc;
		events[ST_OV]   = ov;
		// deferred in soft-start
		// only regulation counts, so a timeout retry never reports undervoltage too
		events[ST_UV]   = uv & cur_reg.ssDone & (cur_reg.state == ST_RUN);
		events[ST_TON]  = uv & ~cur_reg.ssDone & cur_reg.state == ST_SOFT
			& cur_reg.timer >= 19'(cur_reg.ssTime);
		events[ST_OT]   = ot;
		events[ST_BGOT] = bgOt;
		events[ST_UVLO] = uvlo;
		events[ST_WARN] = wOc | wOv | wOt | wUv;
		// status flags, set wins over clear
		if (apbWr && paddr == OFS_STATUS)
			cur_next.status = cur_reg.status & ~pwdata[NSTAT-1:0];
		cur_next.status = cur_next.status | events;
		if (apbWr && paddr == OFS_RESP)
			cur_next.resp = pwdata[RESP_W-1:0];
		if (apbWr && paddr == OFS_MASK)
			cur_next.mask = pwdata[NSTAT-1:0];
		if (apbWr && paddr == OFS_SSTIME && pwdata[15:0] != 16'h0000)
			cur_next.ssTime = pwdata[15:0];
		if (apbRd) begin
			unique case (paddr)
				OFS_RESP:   cur_next.rdata = 32'(cur_reg.resp);
				OFS_MASK:   cur_next.rdata = 32'(cur_reg.mask);
				OFS_STATUS: cur_next.rdata = 32'(cur_reg.status);
				OFS_STATE:  cur_next.rdata = 32'({cur_reg.ssDone, cur_reg.state});
				OFS_SSTIME: cur_next.rdata = 32'(cur_reg.ssTime);
				default:    cur_next.rdata = 32'h0000_0000;
			endcase
		end
		cur_next.timer = cur_reg.timer + 19'h00001;
		unique case (cur_reg.state)
			ST_SOFT: begin
				if (19'(cur_reg.ssTime) <= cur_reg.timer)
					cur_next.ssDone = 1'b1;
				if (cur_reg.ssDone)
					cur_next.state = ST_RUN;
			end
			ST_RUN: ;
			ST_OCDLY: begin
				if (tickPulse)
					cur_next.ocCnt = cur_reg.ocCnt + 2'h1;
				if (tickPulse && cur_reg.ocCnt == 2'(OC_DELAY_COUNTS - 1)) begin
					cur_next.timer = '0;
					cur_next.state = cur_reg.waitCool ? ST_WAIT : ST_LATCH;
				end
			end
			ST_OFF: begin
				// low side discharges until feedback is low unless latched
				if (cur_reg.discharge && fbLow && cur_reg.resp[POS_OVSEL]) begin
					cur_next.discharge = 1'b0;
					cur_next.timer = '0;
					cur_next.state = cur_reg.waitCool ? ST_WAIT : ST_LATCH;
				end
			end
			ST_WAIT: begin
				if (restartDue) begin
					cur_next.state = ST_SOFT;
					cur_next.timer = '0;
					cur_next.ssDone = 1'b0;
					cur_next.waitCool = 1'b0;
				end
			end
			ST_LATCH: ;
			default: cur_next.state = ST_LATCH;
		endcase
		// fault dispatch only in soft-start and run
		if (cur_reg.state == ST_SOFT || cur_reg.state == ST_RUN) begin
			if ((lsOc && !ignLs) || (hsOc && !ignHs)) begin
				cur_next.state = ST_OCDLY;
				cur_next.ocCnt = '0;
				cur_next.waitCool = lsOc && !ignLs
					? respOf(cur_reg.resp, POS_LSOC) == RESP_RESTART
					: respOf(cur_reg.resp, POS_HSOC) == RESP_RESTART;
			end
			if (ov && !ignOv) begin
				cur_next.state = ST_OFF;
				cur_next.discharge = 1'b1;
				cur_next.waitCool = respOf(cur_reg.resp, POS_OV) == RESP_RESTART;
			end
			if ((events[ST_UV] && respOf(cur_reg.resp, POS_UV) != RESP_IGNORE)
				|| (events[ST_TON] && respOf(cur_reg.resp, POS_TON) != RESP_IGNORE)) begin
				cur_next.state = ST_OFF;
				cur_next.discharge = 1'b0;
				cur_next.waitCool = events[ST_UV]
					? respOf(cur_reg.resp, POS_UV) == RESP_RESTART
					: respOf(cur_reg.resp, POS_TON) == RESP_RESTART;
			end
		end
		// temperature and uvlo shut down, never ignored for bandgap or uvlo
		if ((ot && respOf(cur_reg.resp, POS_OT) != RESP_IGNORE) || bgOt || uvlo) begin
			cur_next.state = ST_OFF;
			cur_next.discharge = 1'b0;
			cur_next.waitCool = 1'b0;
		end
		if (cur_reg.state == ST_OFF && !cur_reg.discharge && !uvlo && !bgOt
			&& !(ot && respOf(cur_reg.resp, POS_OT) != RESP_IGNORE)) begin
			// cooled by 20 degrees before leaving
			if (cool || !cur_reg.status[ST_OT]) begin
				cur_next.timer = '0;
				cur_next.state = (cur_reg.status[ST_UV] || cur_reg.status[ST_TON])
					&& !cur_reg.waitCool ? ST_LATCH : ST_WAIT;
			end
		end
		// outputs
		cur_next.hs = 1'b0;
		cur_next.ls = 1'b0;
		if (cur_reg.state == ST_RUN || cur_reg.state == ST_SOFT || cur_reg.state == ST_OCDLY) begin
			cur_next.hs = pwm;
			cur_next.ls = ~pwm;
		end
		if (cur_reg.state == ST_OFF && cur_reg.discharge)
			cur_next.ls = 1'b1;
		// peak limit while high-side overcurrent is ignored
		cur_next.peak = ignHs;
		if (ignHs && hsOc)
			cur_next.hs = 1'b0;
		cur_next.pg = cur_reg.state == ST_RUN && !uvlo
			&& !(wOc && !ignLs) && !(wOv && !ignOv)
			&& !(wOt && respOf(cur_reg.resp, POS_OT) != RESP_IGNORE)
			&& !(wUv && respOf(cur_reg.resp, POS_UV) != RESP_IGNORE);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur_reg <= '0;
			cur_reg.resp <= RESP_RST;
			cur_reg.mask <= MASK_RST;
			cur_reg.ssTime <= 16'(SS_DEFAULT);
			cur_reg.state <= ST_SOFT;
		end else begin
			cur_reg <= cur_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata = cur_reg.rdata;
	assign pready = psel & penable;
	assign pslverr = 1'b0;
	assign highSideOn = cur_reg.hs;
	assign lowSideOn = cur_reg.ls;
	assign peakLimitEn = cur_reg.peak;
	assign softStartActive = cur_reg.state == ST_SOFT;
	assign power_good_out = cur_reg.pg;
	assign alertOut_n = ~|(cur_reg.status & ~cur_reg.mask);

	////////////////////////////////////////////////////////////////////////
	// latch stays off
	AST_LATCH_OFF: assert property (@(posedge ref_clk) disable iff (rst)
		cur_reg.state == ST_LATCH |=> !highSideOn && !power_good_out)
		else $error("latched state drove a switch");
	AST_UVLO: assert property (@(posedge ref_clk) disable iff (rst)
		uvlo |-> ##2 (!highSideOn && !power_good_out))
		else $error("uvlo did not shut down");
	AST_ALERT: assert property (@(posedge ref_clk) disable iff (rst)
		(cur_reg.status[ST_UVLO] && !cur_reg.mask[ST_UVLO]) |-> !alertOut_n)
		else $error("alert missing");
	AST_OV_LS: assert property (@(posedge ref_clk) disable iff (rst)
		(cur_reg.state == ST_OFF && cur_reg.discharge) |=> lowSideOn && !highSideOn)
		else $error("overvoltage discharge not held");
	AST_UV_DEFER: assert property (@(posedge ref_clk) disable iff (rst)
		(softStartActive && !cur_reg.status[ST_UV]) |=> !cur_reg.status[ST_UV])
		else $error("undervoltage acted on early");
	AST_PEAK: assert property (@(posedge ref_clk) disable iff (rst)
		(ignHs && hsOc) |=> !highSideOn)
		else $error("peak limit missed");
	AST_BGOT: assert property (@(posedge ref_clk) disable iff (rst)
		bgOt |=> cur_reg.state == ST_OFF)
		else $error("bandgap overtemperature ignored");
	AST_RESTART: assert property (@(posedge ref_clk) disable iff (rst)
		(cur_reg.state == ST_WAIT && restartDue && !bgOt && !uvlo && !ot && !ov)
		|=> cur_reg.state == ST_SOFT)
		else $error("restart not taken");
	AST_PG: assert property (@(posedge ref_clk) disable iff (rst)
		cur_reg.state != ST_RUN |=> !power_good_out)
		else $error("power-good high during fault");
	// third modulation count ends the delay
	sequence s_ocDelayEnds;
		cur_reg.state == ST_OCDLY && tickPulse && cur_reg.ocCnt == 2'(OC_DELAY_COUNTS - 1);
	endsequence
	sequence s_noShutdown;
		!bgOt && !uvlo && !ot;
	endsequence
	AST_OC_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
		s_ocDelayEnds ##0 s_noShutdown ##0 !cur_reg.waitCool
		|=> cur_reg.state == ST_LATCH)
		else $error("overcurrent latch-off not taken");
	AST_OC_RESTART: assert property (@(posedge ref_clk) disable iff (rst)
		s_ocDelayEnds ##0 s_noShutdown ##0 cur_reg.waitCool
		|=> cur_reg.state == ST_WAIT)
		else $error("overcurrent restart not scheduled");
	AST_IGNORE_OC: assert property (@(posedge ref_clk) disable iff (rst)
		(cur_reg.state == ST_RUN && lsOc && ignLs && !hsOc && !ov && !uv && !ot && !bgOt
		&& !uvlo) |=> cur_reg.state == ST_RUN)
		else $error("ignored overcurrent left run");
endmodule : fault_resp_ctrl
`default_nettype wire

// ---- testbench/stage_model.sv ----
// behavioural power stage: modulator ticks and output discharge sense
`timescale 1ns/100ps
`default_nettype none
module stage_model (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// switch drives from the controller
	input  wire logic highSideOn,
	input  wire logic lowSideOn,
	// modulator and feedback sense
	output logic      pwmTick,
	output logic      pwmHigh,
	output logic      fbBelowDischarge
);
	logic [2:0] phase;
	logic [3:0] charge;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase  <= 3'h0;
			charge <= 4'hf;
		end else begin
			phase <= phase + 3'h1;
			// output sags only while the low side conducts alone
			if (lowSideOn && !highSideOn && charge != 4'h0) begin
				charge <= charge - 4'h1;
			end else if (highSideOn) begin
				charge <= 4'hf;
			end
		end
	end
	// one tick per eight clocks keeps three counts well apart
	assign pwmTick          = (phase == 3'h0);
	assign pwmHigh          = !phase[2];
	assign fbBelowDischarge = (charge == 4'h0);
endmodule : stage_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the fault-response controller
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import fault_resp_pkg::*;
;
	localparam int SS = 10;
	logic        ref_clk, rst, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, pwmTick, pwmHigh, fbBelowDischarge;
	logic        highSideOn, lowSideOn, peakLimitEn, softStartActive, power_good_out, alertOut_n;
	logic [11:0] sense;
	int          fails, nChecks, n;
	fault_resp_ctrl #(.SS_DEFAULT(SS)) u_dut (
		.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pwmTick, .pwmHigh, .lowSideOc(sense[0]), .highSideOc(sense[1]), .outOv(sense[2]),
		.outUv(sense[3]), .fbBelowDischarge, .overTemp(sense[4]), .tempCooled(sense[5]),
		.bandgapOt(sense[6]), .inputUvlo(sense[7]), .ocWarn(sense[8]), .ovWarn(sense[9]),
		.otWarn(sense[10]), .uvWarn(sense[11]), .highSideOn, .lowSideOn, .peakLimitEn,
		.softStartActive, .power_good_out, .alertOut_n);
	stage_model u_stage (.ref_clk, .rst, .highSideOn, .lowSideOn, .pwmTick, .pwmHigh,
		.fbBelowDischarge);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d fails %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc
	// request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'b1;
		i = 0;
		do begin
			cyc(1);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			fails++;
			close_out();
		end
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next call never re-drives psel in this step
		cyc(1);
	endtask : apb
	task automatic rstDut(input logic [11:0] s, input int post);
		rst   <= 1'b1;
		sense <= s;
		cyc(20);
		rst <= 1'b0;
		cyc(post);
	endtask : rstDut
	task automatic waitOff(output int i);
		i = 0;
		while ((highSideOn | lowSideOn) !== 1'b0 && i < 200) begin
			cyc(1);
			i++;
		end
		if (i >= 200) begin
			fails++;
			close_out();
		end
	endtask : waitOff
	task automatic ssWithin(input int lo, input int hi);
		int i;
		i = 0;
		while (softStartActive !== 1'b1 && i <= hi) begin
			cyc(1);
			i++;
		end
		chk(32'(i >= lo && i <= hi), 32'h1);
	endtask : ssWithin
	////////////////////////////////////////////////////////////////////////////
	task automatic tRegs();
		rstDut(12'h0, 2 * SS);
		apb(1'b0, OFS_RESP, 32'h0);
		chk(q, 32'(RESP_RST));
		apb(1'b0, OFS_MASK, 32'h0);
		chk(q, 32'(MASK_RST));
		// zero soft-start time would stall restarts, so it is refused
		apb(1'b1, OFS_SSTIME, 32'h0);
		apb(1'b0, OFS_SSTIME, 32'h0);
		chk(q, 32'(SS));
		apb(1'b1, 8'h14, 32'hffff_ffff);
		apb(1'b0, 8'h14, 32'h0);
		chk(q, 32'h0);
		chk(32'(pslverr), 32'h0);
	endtask : tRegs
	task automatic tLatch();
		rstDut(12'h0, 2 * SS);
		// one response word, as for both stacked devices
		apb(1'b1, OFS_RESP, 32'h0554);
		sense[0] <= 1'b1;
		waitOff(n);
		chk(32'(n >= 14), 32'h1);
		chk(32'(power_good_out), 32'h0);
		chk(32'(alertOut_n), 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q & 32'h1, 32'h1);
		sense[0] <= 1'b0;
		cyc(100);
		chk(32'({highSideOn, lowSideOn, power_good_out}), 32'h0);
		apb(1'b1, OFS_STATUS, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		chk(32'(alertOut_n), 32'h1);
	endtask : tLatch
	task automatic tRestart();
		for (int k = 0; k < 3; k++) begin
			rstDut(12'h0, 2 * SS);
			apb(1'b1, OFS_MASK, (k == 0) ? 32'h1 : 32'h0);
			sense[k == 2 ? 3 : k] <= 1'b1;
			waitOff(n);
			sense <= 12'h0;
			chk(32'(k == 2 || n >= 14), 32'h1);
			chk(32'(power_good_out), 32'h0);
			chk(32'(alertOut_n), 32'(k == 0));
			ssWithin(7 * SS - 8, 7 * SS + 12);
		end
	endtask : tRestart
	task automatic tIgnore();
		logic [2:0] seen;
		rstDut(12'h0, 2 * SS);
		apb(1'b1, OFS_RESP, 32'h0aaa);
		// one full modulation period, since switch levels follow the pwm phase
		for (int w = 0; w < 2; w++) begin
			sense <= w ? 12'h103 : 12'h101;
			cyc(60);
			seen = 3'b001;
			for (int c = 0; c < 8; c++) begin
				seen = (seen & {2'b11, power_good_out}) | {highSideOn, lowSideOn, 1'b0};
				cyc(1);
			end
			chk(32'(seen), w ? 32'h3 : 32'h7);
		end
		chk(32'(peakLimitEn), 32'h1);
		sense <= 12'h0;
		apb(1'b1, OFS_RESP, 32'(RESP_RST));
		sense <= 12'h700;
		cyc(10);
		chk(32'(power_good_out), 32'h0);
		apb(1'b0, OFS_STATE, 32'h0);
		chk(q & 32'h7, 32'(ST_RUN));
	endtask : tIgnore
	task automatic tOv(input logic [31:0] resp);
		rstDut(12'h0, 2 * SS);
		apb(1'b1, OFS_RESP, resp);
		sense[2] <= 1'b1;
		cyc(8);
		chk(32'({highSideOn, lowSideOn}), 32'h1);
		sense[2] <= 1'b0;
		if (resp[12]) begin
			waitOff(n);
			chk(32'({n >= 8, power_good_out}), 32'h2);
			ssWithin(7 * SS - 8, 7 * SS + 12);
		end else begin
			cyc(100);
			chk(32'({highSideOn, lowSideOn, power_good_out}), 32'h2);
		end
	endtask : tOv
	task automatic tHeat();
		rstDut(12'h0, 2 * SS);
		sense[4] <= 1'b1;
		waitOff(n);
		sense[4] <= 1'b0;
		cyc(120);
		chk(32'({highSideOn, lowSideOn, softStartActive}), 32'h0);
		sense[5] <= 1'b1;
		ssWithin(0, 7 * SS + 12);
		for (int b = 6; b < 8; b++) begin
			rstDut(12'h0, 2 * SS);
			apb(1'b1, OFS_RESP, 32'h0aaa);
			sense[b] <= 1'b1;
			waitOff(n);
			cyc(2);
			chk(32'({power_good_out, alertOut_n}), 32'h0);
		end
	endtask : tHeat
	task automatic tStartUv();
		rstDut(12'h008, 4);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q & 32'h18, 32'h0);
		cyc(2 * SS);
		waitOff(n);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q & 32'h18, 32'h10);
	endtask : tStartUv
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h0;
		pwdata  = 32'h0;
		sense   = 12'h0;
		fails   = 0;
		nChecks = 0;
		tRegs();
		tLatch();
		tRestart();
		tIgnore();
		tOv(32'h0545);
		tOv(32'h1555);
		tHeat();
		tStartUv();
		close_out();
	end
endmodule : tb_top
`default_nettype wire
